// *** icpd_pkg.sv ***
// Constants and types shared by the interval clock and programmed I/O dispatch logic.
// Assumes a single 250 MHz clock domain with a synchronous active-low reset.
//
// How it works
// - Enabled interval clock turns each 250 Hz timing pulse into a fetch-cycle trap.
// - That fetch-cycle trap becomes an external interrupt request.
// - Clock interrupt is dropped while interrupts are disabled, serviced when enabled.
// - Input function 11 returns controller identifier; function 13 returns interrupt vector.
// - Control pulse function 0 starts the timer; function 2 stops it.
// - Control pulse function 1 clears a pending phantom interrupt code interrupt.
// - Control pulse function 17 octal initialises the interval timer.
// - Output function 13 writes vector; function 7 also passes accumulator data out.
// - Skip function 0 skips when the timer is not requesting an interrupt.
// - In V and I modes clock commands come through the extended-I/O instruction.
// - S/R operative: type bits 1-2, 1100 in 3-6, function 7-10, address 11-16.
// - Type 00 control pulse, 01 skip, 11 output, 10 input.
// - In V mode direct programmed I/O instructions do not execute.
// - Extended-I/O executes effective address bits 17-32 as the operative.
// - Missing memory, uncorrected ECC, machine check and parity traps raise only a check report.
// - External, memory increment and interval timer traps raise an interrupt break.
// - Integer exception, access and restricted mode violations raise a fault.
// - Lookaside buffer miss may raise page fault or segment fault.
// - Unclassified traps cause no further action.
// - Four-bit function selects one of sixteen controller-defined commands per operation.
// - Interval clock lives at controller address octal 20.
package icpd_pkg;

  // ----------------------------------------------------------------
  // Operative layout (bit 1 of the manual is bit 15 here)
  // ----------------------------------------------------------------
  localparam int OP_TYPE_HI = 15;
  localparam int OP_TYPE_LO = 14;
  localparam int OP_EXT_HI = 13;
  localparam int OP_EXT_LO = 10;
  localparam int OP_FUNC_HI = 9;
  localparam int OP_FUNC_LO = 6;
  localparam int OP_ADDR_HI = 5;
  localparam int OP_ADDR_LO = 0;
  localparam logic [3:0] SR_EXT_CODE = 4'hC;
  localparam logic [5:0] CLOCK_CTRL_ADDR = 6'h10;

  // ----------------------------------------------------------------
  // Basic operation types and clock functions
  // ----------------------------------------------------------------
  localparam logic [1:0] TYPE_CTRL_PULSE = 2'h0;
  localparam logic [1:0] TYPE_SKIP = 2'h1;
  localparam logic [1:0] TYPE_INPUT = 2'h2;
  localparam logic [1:0] TYPE_OUTPUT = 2'h3;
  localparam logic [3:0] FN_START = 4'h0;
  localparam logic [3:0] FN_CLR_PIC = 4'h1;
  localparam logic [3:0] FN_STOP = 4'h2;
  localparam logic [3:0] FN_INIT = 4'hF;
  localparam logic [3:0] FN_DATA_OUT = 4'h7;
  localparam logic [3:0] FN_READ_ID = 4'h9;
  localparam logic [3:0] FN_VECTOR = 4'hB;
  localparam logic [3:0] FN_SKIP_IDLE = 4'h0;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_HZ = 250;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam logic [15:0] VECTOR_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Processor modes and trap classes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_S, MODE_R, MODE_V, MODE_I} icpd_mode_t;

  typedef enum logic [3:0] {
    TRAP_NONE, TRAP_MISSING_MEM, TRAP_ECC_UNCORR, TRAP_MACHINE_CHECK, TRAP_PARITY,
    TRAP_EXT_INT, TRAP_MEM_INCR, TRAP_TIMER, TRAP_INT_EXC, TRAP_ACCESS,
    TRAP_RESTRICT, TRAP_SEG_LOOKASIDE, TRAP_POWER_FAIL, TRAP_ECC_CHECK, TRAP_OTHER
  } icpd_trap_t;

  typedef enum logic [2:0] {
    BRK_NONE, BRK_REPORT_CHECK, BRK_INTERRUPT, BRK_FAULT, BRK_PAGE_SEG_FAULT, BRK_CHECK
  } icpd_break_t;

endpackage

// *** icpd_tick_div.sv ***
// Divider turning the fast clock into a one-cycle interval pulse.
// Assumes a single clock; counting runs only while enabled.
`timescale 1ns/1ps
module icpd_tick_div #(
  parameter int DIVISOR = icpd_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Control
  input wire logic run,
  input wire logic restart,
  // Pulse
  output logic tick
);
  import icpd_pkg::*;

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } icpd_div_state_t;

  icpd_div_state_t s_q;
  icpd_div_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.count = 32'h0;
    end else if (run) begin
      if (s_q.count == 32'(DIVISOR - 1)) begin
        s_d.count = 32'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.count = s_q.count + 32'h1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  property p_tick_needs_run;
    @(posedge CLOCK) disable iff (!RST_N) tick |-> $past(run) && !$past(restart);
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run) else $error("Tick without run.");
endmodule // icpd_tick_div

// *** icpd_trap_class.sv ***
// Classifier mapping a trap class onto the software break it causes.
// Assumes the trap code is stable in the cycle it is flagged valid.
`timescale 1ns/1ps
module icpd_trap_class (
  // Trap in
  input wire logic trap_valid,
  input icpd_pkg::icpd_trap_t trap_code,
  // Break out
  output icpd_pkg::icpd_break_t break_kind
);
  import icpd_pkg::*;

  always_comb begin
    break_kind = BRK_NONE;
    if (trap_valid) begin
      case (trap_code)
        TRAP_MISSING_MEM, TRAP_ECC_UNCORR, TRAP_MACHINE_CHECK, TRAP_PARITY:
          break_kind = BRK_REPORT_CHECK;
        TRAP_EXT_INT, TRAP_MEM_INCR, TRAP_TIMER:
          break_kind = BRK_INTERRUPT;
        TRAP_INT_EXC, TRAP_ACCESS, TRAP_RESTRICT:
          break_kind = BRK_FAULT;
        TRAP_SEG_LOOKASIDE:
          break_kind = BRK_PAGE_SEG_FAULT;
        TRAP_POWER_FAIL, TRAP_ECC_CHECK:
          break_kind = BRK_CHECK;
        default:
          break_kind = BRK_NONE;
      endcase
    end
  end
endmodule // icpd_trap_class

// *** icpd_top.sv ***
// Interval clock controller with programmed I/O decode and trap break classification.
// Assumes operatives arrive as one-cycle strobes from processor logic on the same clock,
// and the timing source pulse is a pin from outside the clock domain.
`timescale 1ns/1ps
module icpd_top #(
  parameter int TICK_DIVISOR = icpd_pkg::TICK_CYCLES,
  parameter logic [15:0] CTRL_ID = 16'h0055 // Arbitrary identifier value.
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Processor state
  input icpd_pkg::icpd_mode_t MODE,
  input wire logic INT_ENABLE,
  input wire logic CLOCK_ENABLE,
  // Timing source: external pulse pin, or internal divider when USE_DIVIDER is high
  input wire logic TIMING_PIN,
  input wire logic USE_DIVIDER,
  // Instruction issue
  input wire logic DIRECT_VALID,
  input wire logic [15:0] DIRECT_WORD,
  input wire logic EIO_VALID,
  input wire logic [31:0] EIO_ADDR,
  input wire logic [15:0] ACC_IN,
  // Instruction results
  output logic DONE,
  output logic ILLEGAL,
  output logic SKIP,
  output logic ACC_LOAD,
  output logic [15:0] ACC_OUT,
  // Controller bus to other controllers
  output logic PIO_STROBE,
  output logic [1:0] PIO_TYPE,
  output logic [3:0] PIO_FUNC,
  output logic [5:0] PIO_ADDR,
  output logic [15:0] PIO_DATA,
  // Fetch-cycle trap and interrupt
  input wire logic FETCH_POINT,
  output logic FETCH_TRAP,
  output logic EXT_INT_REQ,
  output logic INT_DISCARDED,
  output logic TIMER_RUNNING,
  output logic TIMER_PENDING,
  // Trap classification
  input wire logic TRAP_VALID,
  input icpd_pkg::icpd_trap_t TRAP_CODE,
  output icpd_pkg::icpd_break_t BREAK_KIND
);
  import icpd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic running;
    logic tick_pending;
    logic pending;
    logic pic_pending;
    logic [15:0] vector;
    logic done;
    logic illegal;
    logic skip;
    logic acc_load;
    logic [15:0] acc_out;
    logic strobe;
    logic [1:0] ptype;
    logic [3:0] pfunc;
    logic [5:0] paddr;
    logic [15:0] pdata;
    logic fetch_trap;
    logic ext_int;
    logic discarded;
  } icpd_state_t;

  icpd_state_t s_q;
  icpd_state_t s_d;

  logic div_tick;
  logic div_restart;
  logic pin_rise;
  logic tick;
  logic op_valid;
  logic [15:0] op;
  logic [1:0] op_type;
  logic [3:0] op_ext;
  logic [3:0] op_func;
  logic [5:0] op_addr;
  logic v_or_i;
  logic op_ok;
  logic for_clock;

  // ----------------------------------------------------------------
  // Timing source
  // ----------------------------------------------------------------
  // Initialise also restarts the divider so the first interval is full length.
  assign div_restart = s_d.running && !s_q.running || (op_ok && for_clock && op_type == TYPE_CTRL_PULSE
                       && op_func == FN_INIT);

  icpd_tick_div #(
    .DIVISOR(TICK_DIVISOR)
  ) u_div (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .run(s_q.running && USE_DIVIDER),
    .restart(div_restart),
    .tick(div_tick)
  );

  // The edge detector reads only the second and third stages, never the first.
  assign pin_rise = s_q.pin_s2 && !s_q.pin_s3;
  assign tick = USE_DIVIDER ? div_tick : (pin_rise && s_q.running);

  // ----------------------------------------------------------------
  // Operative selection and decode
  // ----------------------------------------------------------------
  assign v_or_i = (MODE == MODE_V) || (MODE == MODE_I);
  assign op = v_or_i ? EIO_ADDR[15:0] : DIRECT_WORD;
  assign op_valid = v_or_i ? EIO_VALID : DIRECT_VALID;
  assign op_type = op[OP_TYPE_HI:OP_TYPE_LO];
  assign op_ext = op[OP_EXT_HI:OP_EXT_LO];
  assign op_func = op[OP_FUNC_HI:OP_FUNC_LO];
  assign op_addr = op[OP_ADDR_HI:OP_ADDR_LO];
  // In V and I modes bits 3-6 extend the type and are not checked.
  assign op_ok = op_valid && (v_or_i || op_ext == SR_EXT_CODE);
  assign for_clock = op_addr == CLOCK_CTRL_ADDR;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pin_s1 = TIMING_PIN;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    s_d.done = 1'b0;
    s_d.illegal = 1'b0;
    s_d.skip = 1'b0;
    s_d.acc_load = 1'b0;
    s_d.strobe = 1'b0;
    s_d.fetch_trap = 1'b0;
    s_d.ext_int = 1'b0;
    s_d.discarded = 1'b0;

    // A direct instruction in V or I mode, or a malformed S/R word, is refused.
    if ((v_or_i && DIRECT_VALID) || (op_valid && !op_ok)) begin
      s_d.illegal = 1'b1;
    end

    if (op_ok) begin
      s_d.done = 1'b1;
      if (!for_clock) begin
        // Other controllers decode their own address on the bus.
        s_d.strobe = 1'b1;
        s_d.ptype = op_type;
        s_d.pfunc = op_func;
        s_d.paddr = op_addr;
        s_d.pdata = ACC_IN;
      end else begin
        case (op_type)
          TYPE_CTRL_PULSE: begin
            case (op_func)
              FN_START: s_d.running = 1'b1;
              FN_STOP: s_d.running = 1'b0;
              FN_CLR_PIC: s_d.pic_pending = 1'b0;
              FN_INIT: begin
                s_d.running = 1'b0;
                s_d.pending = 1'b0;
                s_d.tick_pending = 1'b0;
              end
              default: s_d.done = 1'b1;
            endcase
          end
          TYPE_SKIP: begin
            // State is only looked at here, never cleared.
            if (op_func == FN_SKIP_IDLE) begin
              s_d.skip = !s_q.pending;
            end
          end
          TYPE_INPUT: begin
            if (op_func == FN_READ_ID) begin
              s_d.acc_load = 1'b1;
              s_d.acc_out = CTRL_ID;
            end else if (op_func == FN_VECTOR) begin
              s_d.acc_load = 1'b1;
              s_d.acc_out = s_q.vector;
              // The vector read acknowledges service; a new request in the same cycle still wins.
              s_d.pending = 1'b0;
            end
          end
          TYPE_OUTPUT: begin
            if (op_func == FN_VECTOR) begin
              s_d.vector = ACC_IN;
            end else if (op_func == FN_DATA_OUT) begin
              s_d.strobe = 1'b1;
              s_d.ptype = op_type;
              s_d.pfunc = op_func;
              s_d.paddr = op_addr;
              s_d.pdata = ACC_IN;
            end
          end
          default: s_d.done = 1'b1;
        endcase
      end
    end

    // A pulse waits for the next fetch point; it is taken only while the clock is enabled.
    if (tick && CLOCK_ENABLE) begin
      s_d.tick_pending = 1'b1;
    end
    if (s_q.tick_pending && FETCH_POINT) begin
      s_d.tick_pending = tick && CLOCK_ENABLE;
      s_d.fetch_trap = 1'b1;
      if (INT_ENABLE) begin
        s_d.ext_int = 1'b1;
        s_d.pending = 1'b1;
        s_d.pic_pending = 1'b1;
      end else begin
        s_d.discarded = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.vector <= VECTOR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Trap classification and outputs
  // ----------------------------------------------------------------
  icpd_trap_class u_class (
    .trap_valid(TRAP_VALID),
    .trap_code(TRAP_CODE),
    .break_kind(BREAK_KIND)
  );

  assign DONE = s_q.done;
  assign ILLEGAL = s_q.illegal;
  assign SKIP = s_q.skip;
  assign ACC_LOAD = s_q.acc_load;
  assign ACC_OUT = s_q.acc_out;
  assign PIO_STROBE = s_q.strobe;
  assign PIO_TYPE = s_q.ptype;
  assign PIO_FUNC = s_q.pfunc;
  assign PIO_ADDR = s_q.paddr;
  assign PIO_DATA = s_q.pdata;
  assign FETCH_TRAP = s_q.fetch_trap;
  assign EXT_INT_REQ = s_q.ext_int;
  assign INT_DISCARDED = s_q.discarded;
  assign TIMER_RUNNING = s_q.running;
  assign TIMER_PENDING = s_q.pending;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_trap_at_fetch;
    @(posedge CLOCK) disable iff (!RST_N) FETCH_TRAP |-> $past(FETCH_POINT);
  endproperty
  a_trap_at_fetch: assert property (p_trap_at_fetch) else $error("Trap off fetch point.");

  property p_int_from_trap;
    @(posedge CLOCK) disable iff (!RST_N) EXT_INT_REQ |-> FETCH_TRAP && $past(INT_ENABLE);
  endproperty
  a_int_from_trap: assert property (p_int_from_trap) else $error("Interrupt without trap.");

  property p_discard;
    @(posedge CLOCK) disable iff (!RST_N) FETCH_TRAP && !$past(INT_ENABLE) |-> INT_DISCARDED && !EXT_INT_REQ;
  endproperty
  a_discard: assert property (p_discard) else $error("Interrupt not discarded.");

  property p_start;
    @(posedge CLOCK) disable iff (!RST_N)
      op_ok && for_clock && op_type == TYPE_CTRL_PULSE && op_func == FN_START |=> TIMER_RUNNING;
  endproperty
  a_start: assert property (p_start) else $error("Start failed.");

  property p_stop;
    @(posedge CLOCK) disable iff (!RST_N)
      op_ok && for_clock && op_type == TYPE_CTRL_PULSE && op_func == FN_STOP |=> !TIMER_RUNNING;
  endproperty
  a_stop: assert property (p_stop) else $error("Stop failed.");

  property p_read_id;
    @(posedge CLOCK) disable iff (!RST_N)
      op_ok && for_clock && op_type == TYPE_INPUT && op_func == FN_READ_ID |=> ACC_LOAD && ACC_OUT == CTRL_ID;
  endproperty
  a_read_id: assert property (p_read_id) else $error("Identifier not loaded.");

  property p_vec_round;
    @(posedge CLOCK) disable iff (!RST_N)
      op_ok && for_clock && op_type == TYPE_OUTPUT && op_func == FN_VECTOR |=> s_q.vector == $past(ACC_IN);
  endproperty
  a_vec_round: assert property (p_vec_round) else $error("Vector not written.");

  property p_skip;
    @(posedge CLOCK) disable iff (!RST_N)
      op_ok && for_clock && op_type == TYPE_SKIP && op_func == FN_SKIP_IDLE && !s_q.pending |=> SKIP;
  endproperty
  a_skip: assert property (p_skip) else $error("Skip missed.");

  property p_clr_pic;
    @(posedge CLOCK) disable iff (!RST_N)
      op_ok && for_clock && op_type == TYPE_CTRL_PULSE && op_func == FN_CLR_PIC
      && !(s_q.tick_pending && FETCH_POINT && INT_ENABLE) |=> !s_q.pic_pending;
  endproperty
  a_clr_pic: assert property (p_clr_pic) else $error("Phantom interrupt not cleared.");

  property p_v_direct;
    @(posedge CLOCK) disable iff (!RST_N) v_or_i && DIRECT_VALID && !EIO_VALID |=> ILLEGAL && !DONE;
  endproperty
  a_v_direct: assert property (p_v_direct) else $error("Direct op ran in V mode.");
endmodule // icpd_top

// *** icpd_ctrl_model.sv ***
// Behavioural peripheral controller that listens on the programmed I/O bus.
// Assumes the bus fields are valid in the cycle that carries the strobe.
`timescale 1ns/1ps
module icpd_ctrl_model #(
  parameter logic [5:0] MY_ADDR = 6'h05
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Programmed I/O bus
  input wire logic pio_strobe,
  input wire logic [1:0] pio_type,
  input wire logic [3:0] pio_func,
  input wire logic [5:0] pio_addr,
  input wire logic [15:0] pio_data,
  // What this controller saw
  output logic [7:0] hits,
  output logic [1:0] last_type,
  output logic [3:0] last_func,
  output logic [15:0] last_data
);
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // A strobe for any other address is ignored, so a shared address would show as a double hit.
  always @(posedge clk) begin
    if (!rst_n) begin
      hits <= 8'h00;
      last_type <= 2'h0;
      last_func <= 4'h0;
      last_data <= 16'h0000;
    end else if (pio_strobe === 1'b1 && pio_addr === MY_ADDR) begin
      hits <= hits + 8'h01;
      last_type <= pio_type;
      last_func <= pio_func;
      last_data <= pio_data;
    end
  end
endmodule // icpd_ctrl_model

// *** interval_clock_pio_dispatch_tb_top.sv ***
// Self-checking testbench for the interval clock and programmed I/O dispatch block.
// Assumes a 250 MHz clock and a shortened tick divisor of 10 cycles.
`timescale 1ns/1ps
module interval_clock_pio_dispatch_tb_top;
  import icpd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic CLOCK = 1'b0, RST_N = 1'b0, INT_ENABLE = 1'b1, CLOCK_ENABLE = 1'b0, TIMING_PIN = 1'b0;
  logic USE_DIVIDER = 1'b1, DIRECT_VALID = 1'b0, EIO_VALID = 1'b0, FETCH_POINT = 1'b0, TRAP_VALID = 1'b0;
  logic [15:0] DIRECT_WORD = 16'h0000, ACC_IN = 16'h0000;
  logic [31:0] EIO_ADDR = 32'h00000000;
  icpd_mode_t MODE = MODE_S;
  icpd_trap_t TRAP_CODE = TRAP_NONE;
  logic DONE, ILLEGAL, SKIP, ACC_LOAD, PIO_STROBE, FETCH_TRAP, EXT_INT_REQ, INT_DISCARDED;
  logic TIMER_RUNNING, TIMER_PENDING;
  logic [15:0] ACC_OUT, PIO_DATA;
  logic [1:0] PIO_TYPE, m_type;
  logic [3:0] PIO_FUNC, m_func;
  logic [5:0] PIO_ADDR;
  logic [7:0] m_hits;
  logic [15:0] m_data;
  icpd_break_t BREAK_KIND;
  int n_errors = 0, num_checks = 0;
  localparam logic [15:0] ID_VAL = 16'h3A6C; // Arbitrary identifier for this run.
  localparam logic [5:0] FAR_ADDR = 6'h05;

  always #2 CLOCK = ~CLOCK;

  icpd_top #(.TICK_DIVISOR(10), .CTRL_ID(ID_VAL)) uut (.CLOCK(CLOCK), .RST_N(RST_N), .MODE(MODE),
    .INT_ENABLE(INT_ENABLE), .CLOCK_ENABLE(CLOCK_ENABLE), .TIMING_PIN(TIMING_PIN), .USE_DIVIDER(USE_DIVIDER),
    .DIRECT_VALID(DIRECT_VALID), .DIRECT_WORD(DIRECT_WORD), .EIO_VALID(EIO_VALID), .EIO_ADDR(EIO_ADDR),
    .ACC_IN(ACC_IN), .DONE(DONE), .ILLEGAL(ILLEGAL), .SKIP(SKIP), .ACC_LOAD(ACC_LOAD), .ACC_OUT(ACC_OUT),
    .PIO_STROBE(PIO_STROBE), .PIO_TYPE(PIO_TYPE), .PIO_FUNC(PIO_FUNC), .PIO_ADDR(PIO_ADDR),
    .PIO_DATA(PIO_DATA), .FETCH_POINT(FETCH_POINT), .FETCH_TRAP(FETCH_TRAP), .EXT_INT_REQ(EXT_INT_REQ),
    .INT_DISCARDED(INT_DISCARDED), .TIMER_RUNNING(TIMER_RUNNING), .TIMER_PENDING(TIMER_PENDING),
    .TRAP_VALID(TRAP_VALID), .TRAP_CODE(TRAP_CODE), .BREAK_KIND(BREAK_KIND));

  icpd_ctrl_model #(.MY_ADDR(FAR_ADDR)) far (.clk(CLOCK), .rst_n(RST_N), .pio_strobe(PIO_STROBE),
    .pio_type(PIO_TYPE), .pio_func(PIO_FUNC), .pio_addr(PIO_ADDR), .pio_data(PIO_DATA), .hits(m_hits),
    .last_type(m_type), .last_func(m_func), .last_data(m_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] mk(input logic [1:0] t, input logic [3:0] f, input logic [5:0] a);
    return {t, SR_EXT_CODE, f, a};
  endfunction

  // Issues one operative; on return the one-cycle answer is on the outputs.
  // An idle edge comes first so a valid never rises in the step where it fell.
  task automatic op(input logic extended_io_instr, input logic [15:0] w, input logic [15:0] acc);
    @(posedge CLOCK);
    #1;
    if (extended_io_instr) begin
      EIO_VALID = 1'b1;
      EIO_ADDR = {16'h7A3C, w};
    end else begin
      DIRECT_VALID = 1'b1;
      DIRECT_WORD = w;
    end
    ACC_IN = acc;
    @(posedge CLOCK);
    #1;
    DIRECT_VALID = 1'b0;
    EIO_VALID = 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_start_stop(input icpd_mode_t m, input logic extended_io_instr);
    MODE = m;
    op(extended_io_instr, mk(TYPE_CTRL_PULSE, FN_START, CLOCK_CTRL_ADDR), 16'h0000);
    chk(16'(DONE), 16'h0001, "start done");
    chk(16'(TIMER_RUNNING), 16'h0001, "running");
    op(extended_io_instr, mk(TYPE_CTRL_PULSE, FN_STOP, CLOCK_CTRL_ADDR), 16'h0000);
    chk(16'(TIMER_RUNNING), 16'h0000, "stopped");
    op(extended_io_instr, mk(TYPE_INPUT, FN_READ_ID, CLOCK_CTRL_ADDR), 16'h0000);
    chk(16'(ACC_LOAD), 16'h0001, "id load");
    chk(ACC_OUT, ID_VAL, "id value");
    $display("start/stop/id done in mode %0d", m);
  endtask

  task automatic t_vector;
    MODE = MODE_R;
    op(1'b0, mk(TYPE_OUTPUT, FN_VECTOR, CLOCK_CTRL_ADDR), 16'hA5C3);
    chk(16'(DONE), 16'h0001, "vector write");
    op(1'b0, mk(TYPE_INPUT, FN_VECTOR, CLOCK_CTRL_ADDR), 16'h0000);
    chk(ACC_OUT, 16'hA5C3, "vector read");
    op(1'b0, mk(TYPE_OUTPUT, FN_DATA_OUT, CLOCK_CTRL_ADDR), 16'h5A3C);
    chk(16'(PIO_STROBE), 16'h0001, "data out strobe");
    chk({10'h000, PIO_ADDR}, {10'h000, CLOCK_CTRL_ADDR}, "data out addr");
    chk(PIO_DATA, 16'h5A3C, "data out value");
    $display("vector test done");
  endtask

  task automatic t_foreign;
    MODE = MODE_S;
    for (int t = 0; t < 4; t++) begin
      op(1'b0, mk(2'(t), 4'(t + 3), FAR_ADDR), 16'hC00 + 16'(t));
      chk(16'(PIO_STROBE), 16'h0001, "far strobe");
      chk(16'(PIO_TYPE), 16'(t), "far type");
      @(posedge CLOCK);
      #1;
      chk(16'(m_func), 16'(t + 3), "far func");
    end
    chk(m_data, 16'h0C03, "far data");
    op(1'b0, mk(TYPE_CTRL_PULSE, 4'h4, 6'h06), 16'h0000);
    @(posedge CLOCK);
    #1;
    chk(16'(m_hits), 16'h0004, "far hits");
    $display("foreign address test done");
  endtask

  task automatic t_refuse;
    MODE = MODE_S;
    op(1'b0, {TYPE_CTRL_PULSE, 4'hD, FN_START, CLOCK_CTRL_ADDR}, 16'h0000);
    chk(16'({ILLEGAL, DONE, TIMER_RUNNING}), 16'h0004, "bad code");
    MODE = MODE_V;
    op(1'b0, mk(TYPE_CTRL_PULSE, FN_START, CLOCK_CTRL_ADDR), 16'h0000);
    chk(16'({ILLEGAL, DONE, TIMER_RUNNING}), 16'h0004, "direct in V");
    $display("refusal test done");
  endtask

  task automatic t_tick(input logic pin, input logic int_en, input logic clk_en);
    logic tr, ext, disc;
    tr = 1'b0;
    ext = 1'b0;
    disc = 1'b0;
    MODE = MODE_S;
    USE_DIVIDER = !pin;
    INT_ENABLE = int_en;
    CLOCK_ENABLE = clk_en;
    op(1'b0, mk(TYPE_CTRL_PULSE, FN_START, CLOCK_CTRL_ADDR), 16'h0000);
    TIMING_PIN = pin;
    repeat (40) @(posedge CLOCK);
    #1;
    TIMING_PIN = 1'b0;
    chk(16'(FETCH_TRAP), 16'h0000, "trap before fetch point");
    FETCH_POINT = 1'b1;
    @(posedge CLOCK);
    #1;
    FETCH_POINT = 1'b0;
    for (int i = 0; i < 4; i++) begin
      tr |= FETCH_TRAP;
      ext |= EXT_INT_REQ;
      disc |= INT_DISCARDED;
      @(posedge CLOCK);
      #1;
    end
    chk(16'(tr), 16'(clk_en), "fetch trap");
    chk(16'(ext), 16'(clk_en & int_en), "ext int");
    chk(16'(disc), 16'(clk_en & !int_en), "discarded");
    $display("tick test done pin %0d int %0d en %0d", pin, int_en, clk_en);
  endtask

  task automatic t_pending;
    op(1'b0, mk(TYPE_SKIP, FN_SKIP_IDLE, CLOCK_CTRL_ADDR), 16'h0000);
    chk(16'(SKIP), 16'h0000, "no skip while pending");
    chk(16'(TIMER_PENDING), 16'h0001, "pending kept");
    op(1'b0, mk(TYPE_CTRL_PULSE, FN_CLR_PIC, CLOCK_CTRL_ADDR), 16'h0000);
    chk(16'(DONE), 16'h0001, "clear phantom");
    op(1'b0, mk(TYPE_CTRL_PULSE, FN_INIT, CLOCK_CTRL_ADDR), 16'h0000);
    chk(16'({TIMER_RUNNING, TIMER_PENDING}), 16'h0000, "init");
    op(1'b0, mk(TYPE_SKIP, FN_SKIP_IDLE, CLOCK_CTRL_ADDR), 16'h0000);
    chk(16'(SKIP), 16'h0001, "skip when idle");
    $display("pending test done");
  endtask

  task automatic t_traps;
    icpd_break_t exp [15] = '{BRK_NONE, BRK_REPORT_CHECK, BRK_REPORT_CHECK, BRK_REPORT_CHECK,
      BRK_REPORT_CHECK, BRK_INTERRUPT, BRK_INTERRUPT, BRK_INTERRUPT, BRK_FAULT, BRK_FAULT, BRK_FAULT,
      BRK_PAGE_SEG_FAULT, BRK_CHECK, BRK_CHECK, BRK_NONE};
    for (int i = 0; i < 15; i++) begin
      @(posedge CLOCK);
      #1;
      TRAP_CODE = icpd_trap_t'(i);
      TRAP_VALID = 1'b1;
      #1;
      chk(16'(BREAK_KIND), 16'(exp[i]), "break kind");
      TRAP_VALID = 1'b0;
      #1;
      chk(16'(BREAK_KIND), 16'(BRK_NONE), "no trap");
    end
    $display("trap class test done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLOCK);
    #1;
    RST_N = 1'b1;
    chk(16'({DONE, TIMER_RUNNING, TIMER_PENDING, PIO_STROBE}), 16'h0000, "reset values");
    t_start_stop(MODE_S, 1'b0);
    t_start_stop(MODE_V, 1'b1);
    t_start_stop(MODE_I, 1'b1);
    t_vector();
    t_foreign();
    t_refuse();
    t_tick(1'b0, 1'b1, 1'b0);
    t_tick(1'b1, 1'b1, 1'b1);
    t_pending();
    t_tick(1'b0, 1'b0, 1'b1);
    t_traps();
    test_done();
  end

  initial begin
    #100000;
    n_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    test_done();
  end
endmodule // interval_clock_pio_dispatch_tb_top
